// ===== sacl_clk_sink.sv
/*
  Sink model of the logic clocked from the programmable clock output: it times each phase in pclk cycles.
  Assumes the observed clock is a registered output on pclk.
*/
`timescale 1ns/1ps
module sacl_clk_sink (
	// Sampling clock
	input wire logic pclk,
	// Observed clock and the shortest legal high phase
	input wire logic clk_in,
	input wire logic [15:0] min_high,
	// Measured phase lengths and count of short high phases
	output logic [15:0] hi_len,
	output logic [15:0] lo_len,
	output logic [15:0] runt_cnt
);
	logic prev_q; // Level seen on the last edge
	logic [15:0] cnt_q; // Length of the running phase
	initial begin
		prev_q = 1'b0;
		cnt_q = 16'h0001;
		hi_len = 16'h0000;
		lo_len = 16'h0000;
		runt_cnt = 16'h0000;
	end
	// Close a phase at each level change; a short high phase upsets clocked logic
	always @(posedge pclk) begin
		if (clk_in === prev_q) begin
			cnt_q <= cnt_q + 16'h0001;
		end else begin
			if (prev_q) begin
				hi_len <= cnt_q;
				if (cnt_q < min_high) begin // Runt pulse
					runt_cnt <= runt_cnt + 16'h0001;
				end
			end else begin
				lo_len <= cnt_q;
			end
			cnt_q <= 16'h0001;
		end
		prev_q <= clk_in;
	end
endmodule

// ===== sacl_clock_ctrl.sv
/*
  Suspend-aware clock control: oscillator and PLL enables, suspend sequencing,
  programmable clock output, power-on reset filter and APB registers.
  Assumes an APB master on pclk; wake-up and supply-detect pins are asynchronous.
*/
//Function
//- PLL multiplies 6 MHz reference to 48 MHz
//- Clock output selectable 3 to 48 MHz; the generator divides the 10 MHz pclk instead, 5 MHz down to 312.5 kHz
//- Suspend turns oscillator and PLL off
//- Oscillator-run bit starts or stops oscillator
//- Four-bit divide field sets output frequency
//- Suspend with slow enabled gives 100 kHz
//- Suspend request pulse, outputs change after 2 ms
//- Wake-up pulse resumes after 0.5 ms delay
//- Supply dips over 11 us make reset
//- Reset starts high, extended after trip crossing
`timescale 1ns/1ps
module sacl_clock_ctrl #(
	parameter int unsigned SUSPEND_DELAY_CYC = sacl_pkg::SUSPEND_DELAY_CYC,
	parameter int unsigned WAKE_DELAY_CYC = sacl_pkg::WAKE_DELAY_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous pins
	input wire logic device_side_wakeup_in,
	input wire logic supply_above_trip_in,
	// Clock and power outputs
	output logic programmable_clock_out,
	output logic suspend_out,
	output logic oscillator_enable,
	output logic pll_enable,
	output logic internal_por
);
	// Register state
	sacl_pkg::sacl_hwcfg_t hwcfg_q; // Hardware configuration fields
	logic susp_req_q; // Suspend request bit
	logic susp_req_prev_q; // Request bit one cycle ago
	logic [31:0] prdata_q; // Read data
	logic pready_q; // Access phase answer
	logic pslverr_q; // Unmapped address answer
	// Suspend sequencing
	sacl_pkg::sacl_state_t state_q; // Suspend state
	logic [sacl_pkg::CNT_W-1:0] cnt_q; // Delay counter
	logic suspend_q; // Suspend output
	logic osc_en_q; // Oscillator enable
	logic pll_en_q; // PLL enable
	logic [sacl_pkg::CNT_W-1:0] lock_cnt_q; // PLL settling counter
	logic pll_locked_q; // PLL output usable
	// Synchronisers
	logic wake_meta_q; // First stage, wake-up
	logic wake_sync_q; // Second stage, wake-up
	logic wake_prev_q; // Edge detector, wake-up
	logic sup_meta_q; // First stage, supply detect
	logic sup_sync_q; // Second stage, supply detect
	// Power-on reset
	logic [sacl_pkg::POR_W-1:0] low_cnt_q; // Cycles of supply below trip
	logic [sacl_pkg::POR_W-1:0] ext_cnt_q; // Extension cycles served
	logic por_q; // Internal reset pulse
	// Clock output selection
	sacl_pkg::sacl_clkmode_t clk_mode; // Requested clock source
	logic clk_out; // Generator output flop

	// APB decode
	wire setup = psel && !penable;
	wire hit_hwcfg = (paddr == sacl_pkg::HWCFG_OFFS);
	wire hit_mode = (paddr == sacl_pkg::MODE_OFFS);
	wire hit_status = (paddr == sacl_pkg::STATUS_OFFS);
	wire mapped = hit_hwcfg || hit_mode || hit_status;
	wire wr_go = psel && penable && pready_q && pwrite && !pslverr_q;
	wire [sacl_pkg::DIV_W-1:0] wr_divide = pwdata[sacl_pkg::DIV_LSB +: sacl_pkg::DIV_W]; // Divide field written
	wire [31:0] hwcfg_rd = {26'h0, hwcfg_q.oscillator_run_bit, hwcfg_q.slow_clock_disable,
		hwcfg_q.clock_divide_factor};
	wire [31:0] mode_rd = {31'h0, susp_req_q};
	wire [31:0] status_rd = {25'h0, clk_mode, por_q, pll_locked_q, state_q, suspend_q};
	wire [31:0] rd_mux = hit_hwcfg ? hwcfg_rd : hit_mode ? mode_rd : hit_status ? status_rd : 32'h00000000;
	// Suspend request is the falling edge of the request bit
	wire susp_req_fall = susp_req_prev_q && !susp_req_q;
	wire wake_rise = wake_sync_q && !wake_prev_q;
	wire cnt_zero = (cnt_q == '0);
	wire awake_side = (state_q == sacl_pkg::SACL_AWAKE) || (state_q == sacl_pkg::SACL_ENTERING);
	wire osc_wanted = hwcfg_q.oscillator_run_bit && (state_q != sacl_pkg::SACL_SUSPENDED);

	// APB answer: zero wait states, data sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q <= setup ? rd_mux : prdata_q;
		end
	end

	// Writable configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hwcfg_q.clock_divide_factor <= sacl_pkg::DIV_RST;
			hwcfg_q.slow_clock_disable <= sacl_pkg::SLOWDIS_RST;
			hwcfg_q.oscillator_run_bit <= sacl_pkg::RUN_RST;
			susp_req_q <= 1'b0;
		end else begin
			if (wr_go && hit_hwcfg) begin
				hwcfg_q.clock_divide_factor <= wr_divide;
				hwcfg_q.slow_clock_disable <= pwdata[sacl_pkg::SLOWDIS_POS];
				hwcfg_q.oscillator_run_bit <= pwdata[sacl_pkg::RUN_POS];
			end
			if (wr_go && hit_mode) begin
				susp_req_q <= pwdata[sacl_pkg::SUSPREQ_POS];
			end
		end
	end

	// Request edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			susp_req_prev_q <= 1'b0;
		end else begin
			susp_req_prev_q <= susp_req_q;
		end
	end

	// Two-stage synchronisers and wake-up edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_meta_q <= 1'b0;
			wake_sync_q <= 1'b0;
			wake_prev_q <= 1'b0;
			sup_meta_q <= 1'b0;
			sup_sync_q <= 1'b0;
		end else begin
			wake_meta_q <= device_side_wakeup_in;
			wake_sync_q <= wake_meta_q;
			wake_prev_q <= wake_sync_q;
			sup_meta_q <= supply_above_trip_in;
			sup_sync_q <= sup_meta_q;
		end
	end

	// Suspend sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sacl_pkg::SACL_AWAKE;
			cnt_q <= '0;
			suspend_q <= 1'b0;
		end else begin
			unique case (state_q)
				sacl_pkg::SACL_AWAKE: begin
					// Request pulse starts the entry delay
					if (susp_req_fall) begin
						state_q <= sacl_pkg::SACL_ENTERING;
						cnt_q <= sacl_pkg::CNT_W'(SUSPEND_DELAY_CYC - 1);
					end
				end
				sacl_pkg::SACL_ENTERING: begin
					// A wake-up during the delay cancels the entry
					if (wake_rise) begin
						state_q <= sacl_pkg::SACL_AWAKE;
					end else if (cnt_zero) begin
						state_q <= sacl_pkg::SACL_SUSPENDED;
						suspend_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				sacl_pkg::SACL_SUSPENDED: begin
					// Wake-up starts the resume delay
					if (wake_rise) begin
						state_q <= sacl_pkg::SACL_RESUMING;
						cnt_q <= sacl_pkg::CNT_W'(WAKE_DELAY_CYC - 1);
					end
				end
				sacl_pkg::SACL_RESUMING: begin
					// Suspend output clears on return to awake; normal clock returns once the PLL is also settled
					if (cnt_zero) begin
						state_q <= sacl_pkg::SACL_AWAKE;
						suspend_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
			endcase
		end
	end

	// Oscillator and PLL enables; PLL restarts during the resume delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en_q <= 1'b0;
			pll_en_q <= 1'b0;
		end else begin
			osc_en_q <= osc_wanted;
			pll_en_q <= osc_wanted;
		end
	end

	// PLL settling: the 48 MHz clock counts as usable after a fixed wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_cnt_q <= '0;
			pll_locked_q <= 1'b0;
		end else if (!pll_en_q) begin
			lock_cnt_q <= '0;
			pll_locked_q <= 1'b0;
		end else if (lock_cnt_q == sacl_pkg::CNT_W'(sacl_pkg::PLL_LOCK_CYC - 1)) begin
			pll_locked_q <= 1'b1;
		end else begin
			lock_cnt_q <= lock_cnt_q + 1'b1;
		end
	end

	// Clock source: normal while awake and locked, slow or static in suspend
	assign clk_mode = (awake_side && pll_locked_q) ? sacl_pkg::SACL_CLK_NORMAL :
		(!awake_side && !hwcfg_q.slow_clock_disable) ? sacl_pkg::SACL_CLK_SLOW :
		sacl_pkg::SACL_CLK_STATIC;

	// Output generator, switching only after a low phase
	sacl_programmable_clock_out_gen u_programmable_clock_out (
		.pclk(pclk),
		.presetn(presetn),
		.mode(clk_mode),
		.divide(hwcfg_q.clock_divide_factor),
		.clk_out_q(clk_out)
	);

	// Power-on reset: dip filter then fixed extension after recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q <= '0;
			ext_cnt_q <= '0;
			por_q <= 1'b1;
		end else if (!sup_sync_q) begin
			ext_cnt_q <= '0;
			if (low_cnt_q == sacl_pkg::POR_W'(sacl_pkg::DIP_CYC)) begin
				por_q <= 1'b1;
			end else begin
				low_cnt_q <= low_cnt_q + 1'b1;
			end
		end else begin
			low_cnt_q <= '0;
			if (por_q && ext_cnt_q == sacl_pkg::POR_W'(sacl_pkg::POR_EXT_CYC - 1)) begin
				por_q <= 1'b0;
			end else if (por_q) begin
				ext_cnt_q <= ext_cnt_q + 1'b1;
			end
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign programmable_clock_out = clk_out;
	assign suspend_out = suspend_q;
	assign oscillator_enable = osc_en_q;
	assign pll_enable = pll_en_q;
	assign internal_por = por_q;

	// Request falling edge loads the full entry delay
	AST_ENTRY_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_AWAKE) && susp_req_fall |=>
		(state_q == sacl_pkg::SACL_ENTERING) && (cnt_q == sacl_pkg::CNT_W'(SUSPEND_DELAY_CYC - 1)))
		else $error("suspend entry delay not loaded");
	// Suspend output rises only when the entry delay ran out
	AST_ENTRY_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(suspend_q) |-> ($past(state_q) == sacl_pkg::SACL_ENTERING) && ($past(cnt_q) == '0))
		else $error("suspend output rose early");
	// Oscillator and PLL are off one cycle into suspend
	AST_OSC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_SUSPENDED) ##1 (state_q == sacl_pkg::SACL_SUSPENDED) |->
		!osc_en_q && !pll_en_q)
		else $error("oscillator running in suspend");
	// Run bit low stops the oscillator
	AST_RUN_BIT: assert property (@(posedge pclk) disable iff (!presetn)
		!hwcfg_q.oscillator_run_bit |=> !osc_en_q)
		else $error("oscillator enabled with run bit low");
	// Resume clears suspend only after the wake delay
	AST_WAKE_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(suspend_q) |-> ($past(state_q) == sacl_pkg::SACL_RESUMING) && ($past(cnt_q) == '0))
		else $error("suspend output cleared early");
	// Wake-up in suspend loads the resume delay
	AST_WAKE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_SUSPENDED) && wake_rise |=>
		(state_q == sacl_pkg::SACL_RESUMING) && (cnt_q == sacl_pkg::CNT_W'(WAKE_DELAY_CYC - 1)))
		else $error("resume delay not loaded");
	// Reset pulse only after a dip longer than the filter
	AST_DIP_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(por_q) |-> $past(low_cnt_q) == sacl_pkg::POR_W'(sacl_pkg::DIP_CYC))
		else $error("reset pulse from a short dip");
	// Reset held for the extension after the supply recovers
	AST_POR_EXT: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(por_q) |-> $past(sup_sync_q) && ($past(ext_cnt_q) == sacl_pkg::POR_W'(sacl_pkg::POR_EXT_CYC - 1)))
		else $error("reset released without extension");
	// Suspend source follows the slow-clock-disable bit
	AST_SUSP_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_SUSPENDED) |->
		(clk_mode == (hwcfg_q.slow_clock_disable ? sacl_pkg::SACL_CLK_STATIC : sacl_pkg::SACL_CLK_SLOW)))
		else $error("wrong clock source in suspend");

	// A wake-up during the entry delay returns to awake without suspending
	AST_ENTRY_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_ENTERING) && wake_rise |=> (state_q == sacl_pkg::SACL_AWAKE) && !suspend_q)
		else $error("suspend entry not cancelled by wake-up");
	// The 48 MHz clock counts as usable only after the full settling wait
	AST_PLL_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pll_locked_q) |-> $past(pll_en_q) && ($past(lock_cnt_q) == sacl_pkg::CNT_W'(sacl_pkg::PLL_LOCK_CYC - 1)))
		else $error("PLL declared usable early");
	// Normal source only while awake with a settled PLL
	AST_NORMAL_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_mode == sacl_pkg::SACL_CLK_NORMAL) |-> awake_side && pll_locked_q && $past(pll_en_q))
		else $error("normal clock source without a running PLL");
	// A configuration write lands in the divide field at the access edge
	AST_DIV_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_go && hit_hwcfg |=> (hwcfg_q.clock_divide_factor == $past(wr_divide)))
		else $error("divide factor write lost");
	// Run bit high while awake keeps oscillator and PLL running
	AST_RUN_ON: assert property (@(posedge pclk) disable iff (!presetn)
		hwcfg_q.oscillator_run_bit && awake_side |=> osc_en_q && pll_en_q)
		else $error("oscillator stopped with run bit high");
	// The reset pulse stays up while the supply is still low
	AST_POR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		por_q && !sup_sync_q |=> por_q)
		else $error("reset pulse dropped with supply low");

	COV_ENTER: cover property (@(posedge pclk) disable iff (!presetn) $rose(suspend_q));
	COV_RESUME: cover property (@(posedge pclk) disable iff (!presetn) $fell(suspend_q));
	COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn)
		(state_q == sacl_pkg::SACL_ENTERING) && wake_rise);
	COV_DIP: cover property (@(posedge pclk) disable iff (!presetn) $rose(por_q));
endmodule

// ===== sacl_pkg.sv
/*
  Constants, field layouts and types shared by the suspend-aware clock output block.
  Assumes a single 10 MHz APB clock; all times are turned into cycles of that clock.
*/
package sacl_pkg;
	// Bus clock rate
	localparam int unsigned PCLK_HZ = 10_000_000;
	localparam int unsigned PCLK_MHZ = PCLK_HZ / 1_000_000;
	// Frequency plan of the reference and the multiplier
	localparam int unsigned REF_MHZ = 6;
	localparam int unsigned PLL_MULT = 8;
	localparam int unsigned PLL_MHZ = REF_MHZ * PLL_MULT;
	localparam int unsigned CLK_OUT_MIN_MHZ = 3;
	// Times as printed
	localparam int unsigned SUSPEND_DELAY_US = 2000;
	localparam int unsigned WAKE_DELAY_US = 500;
	localparam int unsigned SLOW_CLOCK_HZ = 100_000;
	localparam int unsigned DIP_FILTER_NS = 11_000;
	localparam int unsigned POR_EXT_NS = 1000;
	// Times as cycle counts
	localparam int unsigned SUSPEND_DELAY_CYC = SUSPEND_DELAY_US * PCLK_MHZ;
	localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_US * PCLK_MHZ;
	localparam int unsigned DIP_CYC = (DIP_FILTER_NS * PCLK_MHZ + 999) / 1000;
	localparam int unsigned POR_EXT_CYC = (POR_EXT_NS * PCLK_MHZ + 999) / 1000;
	localparam int unsigned SLOW_HALF_CYC = PCLK_HZ / (2 * SLOW_CLOCK_HZ);
	localparam int unsigned PLL_LOCK_CYC = 16;
	// Counter widths
	localparam int unsigned CNT_W = 16;
	localparam int unsigned POR_W = 8;
	localparam int unsigned DIV_W = 4;
	// Register byte offsets
	localparam logic [11:0] HWCFG_OFFS = 12'h000;
	localparam logic [11:0] MODE_OFFS = 12'h004;
	localparam logic [11:0] STATUS_OFFS = 12'h008;
	// Field positions
	localparam int unsigned DIV_LSB = 0;
	localparam int unsigned SLOWDIS_POS = 4;
	localparam int unsigned RUN_POS = 5;
	localparam int unsigned SUSPREQ_POS = 0;
	// Reset values of the configuration fields
	localparam logic [3:0] DIV_RST = 4'h7;
	localparam logic RUN_RST = 1'b1;
	localparam logic SLOWDIS_RST = 1'b0;
	// Configuration carried from the register file to the clock logic
	typedef struct packed {
		logic slow_clock_disable;
		logic oscillator_run_bit;
		logic [3:0] clock_divide_factor;
	} sacl_hwcfg_t;
	// Source of the clock output
	typedef enum logic [1:0] {
		SACL_CLK_NORMAL,
		SACL_CLK_SLOW,
		SACL_CLK_STATIC
	} sacl_clkmode_t;
	// Suspend sequencing
	typedef enum logic [1:0] {
		SACL_AWAKE,
		SACL_ENTERING,
		SACL_SUSPENDED,
		SACL_RESUMING
	} sacl_state_t;
endpackage

// ===== sacl_programmable_clock_out_gen.sv
/*
  Clock output generator: divided normal clock, slow suspend clock or static low.
  Assumes mode and divide come from logic on the same clock.
*/
`timescale 1ns/1ps
module sacl_programmable_clock_out_gen (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Selection
	input wire sacl_pkg::sacl_clkmode_t mode,
	input wire logic [3:0] divide,
	// Clock output
	output logic clk_out_q
);
	sacl_pkg::sacl_clkmode_t cur_mode_q; // Mode in force
	logic [3:0] cur_div_q; // Divide in force
	logic [sacl_pkg::CNT_W-1:0] cnt_q; // Cycles left in this phase
	logic [sacl_pkg::CNT_W-1:0] cur_load; // Reload for the mode in force
	logic [sacl_pkg::CNT_W-1:0] new_load; // Reload for the requested mode
	wire boundary = (cnt_q == '0); // Phase ends this cycle
	wire adopt = boundary && !clk_out_q; // Only at end of a low phase

	// Half period: divide+1 cycles for normal, fixed count for slow
	assign cur_load = (cur_mode_q == sacl_pkg::SACL_CLK_SLOW) ?
		sacl_pkg::CNT_W'(sacl_pkg::SLOW_HALF_CYC - 1) : sacl_pkg::CNT_W'(cur_div_q);
	assign new_load = (mode == sacl_pkg::SACL_CLK_SLOW) ?
		sacl_pkg::CNT_W'(sacl_pkg::SLOW_HALF_CYC - 1) : sacl_pkg::CNT_W'(divide);

	// Selection changes only after a low phase, so no high pulse is cut
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_mode_q <= sacl_pkg::SACL_CLK_STATIC;
			cur_div_q <= sacl_pkg::DIV_RST;
		end else if (adopt) begin
			cur_mode_q <= mode;
			cur_div_q <= divide;
		end
	end

	// Phase counter and output toggle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			clk_out_q <= 1'b0;
		end else if (!boundary) begin
			cnt_q <= cnt_q - 1'b1;
		end else if (clk_out_q) begin
			// High phase over, low phase of equal length
			clk_out_q <= 1'b0;
			cnt_q <= cur_load;
		end else if (mode == sacl_pkg::SACL_CLK_STATIC) begin
			// Held low, checked every cycle
			clk_out_q <= 1'b0;
		end else begin
			clk_out_q <= 1'b1;
			cnt_q <= new_load;
		end
	end

	// Every high phase starts with the full count of the mode in force
	AST_FULL_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clk_out_q) |-> (cnt_q == cur_load) && (cur_mode_q != sacl_pkg::SACL_CLK_STATIC))
		else $error("clock output high phase started short");
	// Static mode keeps the output low
	AST_STATIC_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == sacl_pkg::SACL_CLK_STATIC) && !clk_out_q |=> !clk_out_q)
		else $error("clock output toggled in static mode");
	COV_SLOW_TOGGLE: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(clk_out_q) && (cur_mode_q == sacl_pkg::SACL_CLK_SLOW));
endmodule

// ===== tb_top.sv
/*
  Self-checking testbench of the suspend-aware clock control, with APB tasks and a clock sink model.
  Assumes the shortened suspend and wake delays set below.
*/
`timescale 1ns/1ps
module tb_top;
	localparam int S = 20; // Shortened suspend entry delay
	localparam int W = 10; // Shortened wake delay
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic device_side_wakeup_in = 1'b0;
	logic supply_above_trip_in = 1'b1;
	logic programmable_clock_out, suspend_out, oscillator_enable, pll_enable, internal_por;
	logic [15:0] min_high = 16'h0001; // Shortest legal high phase
	logic [15:0] hi_len, lo_len, runt_cnt, runt_base;
	int err_count = 0;
	int num_checks = 0;
	int tick = 0;
	int n;
	logic [31:0] r;
	logic e, acc;
	logic [3:0] divs [3] = '{4'h0, 4'h3, 4'hF}; // Boundary and middle divide factors
	sacl_clock_ctrl #(.SUSPEND_DELAY_CYC(S), .WAKE_DELAY_CYC(W)) sacl_clock_ctrl_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .device_side_wakeup_in(device_side_wakeup_in),
		.supply_above_trip_in(supply_above_trip_in), .programmable_clock_out(programmable_clock_out),
		.suspend_out(suspend_out), .oscillator_enable(oscillator_enable), .pll_enable(pll_enable),
		.internal_por(internal_por));
	sacl_clk_sink sacl_clk_sink_inst (.pclk(pclk), .clk_in(programmable_clock_out), .min_high(min_high),
		.hi_len(hi_len), .lo_len(lo_len), .runt_cnt(runt_cnt));
	// 10 MHz clock
	always #50 pclk = ~pclk;
	// Cut a hang short
	always @(posedge pclk) begin
		tick++;
		if (tick == 6000) begin
			err_count++;
			final_report();
		end
	end
	task automatic final_report();
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge pclk);
	endtask
	// Let the clock settle, then check both half periods
	task automatic meas(input string name, input logic [31:0] half);
		repeat (3) @(posedge programmable_clock_out);
		cycles(2);
		chk({name, " high"}, {16'h0, hi_len}, half);
		chk({name, " low"}, {16'h0, lo_len}, half);
	endtask
	task automatic pulse_wake();
		@(posedge pclk);
		device_side_wakeup_in <= 1'b1;
		repeat (2) @(posedge pclk);
		device_side_wakeup_in <= 1'b0;
	endtask
	// Full suspend and resume with the slow clock enabled or disabled
	task automatic suspend_cycle(input logic slow_off);
		apb(1'b1, sacl_pkg::HWCFG_OFFS, 32'h23 | (32'(slow_off) << sacl_pkg::SLOWDIS_POS));
		runt_base = runt_cnt;
		min_high <= 16'h0004;
		apb(1'b1, sacl_pkg::MODE_OFFS, 32'h1);
		apb(1'b1, sacl_pkg::MODE_OFFS, 32'h0);
		for (n = 0; suspend_out !== 1'b1 && n < 200; n++) cycles(1);
		chk("suspend delay", 32'(n >= S && n <= S + 3), 32'h1);
		cycles(4);
		chk("osc off", {31'h0, oscillator_enable}, 32'h0);
		chk("pll off", {31'h0, pll_enable}, 32'h0);
		if (!slow_off) begin
			meas("slow", 32'h32);
		end else begin
			cycles(20);
			acc = 1'b0;
			repeat (120) begin
				cycles(1);
				acc = acc | programmable_clock_out;
			end
			chk("static", {31'h0, acc}, 32'h0);
		end
		apb(1'b0, sacl_pkg::STATUS_OFFS, 32'h0);
		chk("status", r & 32'h7F, slow_off ? 32'h45 : 32'h25);
		pulse_wake();
		for (n = 0; suspend_out !== 1'b0 && n < 200; n++) cycles(1);
		chk("wake delay", 32'(n >= W && n <= W + 8), 32'h1);
		cycles(30);
		chk("osc on", {31'h0, oscillator_enable}, 32'h1);
		meas("resumed", 32'h4);
		chk("runts", {16'h0, runt_cnt}, {16'h0, runt_base});
		min_high <= 16'h0001;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1; // Bench acts as the external reset controller
		cycles(2);
		chk("osc on", {31'h0, oscillator_enable}, 32'h1);
		chk("pll on", {31'h0, pll_enable}, 32'h1);
		apb(1'b0, sacl_pkg::HWCFG_OFFS, 32'h0);
		chk("hwcfg reset", r, 32'h27);
		apb(1'b0, sacl_pkg::MODE_OFFS, 32'h0);
		chk("mode reset", r, 32'h0);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		cycles(40);
		chk("por released", {31'h0, internal_por}, 32'h0);
		// Boundary and middle divide factors
		foreach (divs[i]) begin
			apb(1'b1, sacl_pkg::HWCFG_OFFS, 32'h20 | 32'(divs[i]));
			meas("divided", 32'(divs[i]) + 32'h1);
		end
		apb(1'b1, sacl_pkg::HWCFG_OFFS, 32'h03);
		cycles(40);
		chk("run off", {31'h0, oscillator_enable}, 32'h0);
		chk("clock held", {31'h0, programmable_clock_out}, 32'h0);
		suspend_cycle(1'b0);
		suspend_cycle(1'b1);
		// Wake-up during entry cancels it
		apb(1'b1, sacl_pkg::MODE_OFFS, 32'h1);
		apb(1'b1, sacl_pkg::MODE_OFFS, 32'h0);
		cycles(5);
		pulse_wake();
		cycles(S + 20);
		chk("aborted", {31'h0, suspend_out}, 32'h0);
		// Short dip is filtered, long dip resets
		@(posedge pclk);
		supply_above_trip_in <= 1'b0;
		acc = 1'b0;
		repeat (50) begin
			cycles(1);
			acc = acc | internal_por;
		end
		@(posedge pclk);
		supply_above_trip_in <= 1'b1;
		repeat (20) begin
			cycles(1);
			acc = acc | internal_por;
		end
		chk("short dip", {31'h0, acc}, 32'h0);
		@(posedge pclk);
		supply_above_trip_in <= 1'b0;
		cycles(130);
		chk("long dip", {31'h0, internal_por}, 32'h1);
		@(posedge pclk);
		supply_above_trip_in <= 1'b1;
		cycles(6);
		chk("por held", {31'h0, internal_por}, 32'h1);
		cycles(20);
		chk("por end", {31'h0, internal_por}, 32'h0);
		final_report();
	end
endmodule
